// ===== src/wsa_pkg.sv
// Constants shared by the wake and management interrupt aggregator.
// Assumes byte-wide accesses at offsets inside one power-management block.
package wsa_pkg;

	// Register offsets inside the power-management block.
	localparam logic [7:0] OFF_DEV_WAKE_STS = 8'h0c;
	localparam logic [7:0] OFF_GPIO_WAKE_STS = 8'h0d;
	localparam logic [7:0] OFF_DEV_WAKE_EN = 8'h0e;
	localparam logic [7:0] OFF_GPIO_WAKE_EN = 8'h0f;
	localparam logic [7:0] OFF_WAKE_MST_STS = 8'h10;
	localparam logic [7:0] OFF_WAKE_MST_EN = 8'h11;
	localparam logic [7:0] OFF_PERIPH_SMI_STS = 8'h12;
	localparam logic [7:0] OFF_INPUT_SMI_STS = 8'h13;
	localparam logic [7:0] OFF_PERIPH_SMI_EN = 8'h14;
	localparam logic [7:0] OFF_INPUT_SMI_EN = 8'h15;

	// Value of every register after battery power-on reset.
	localparam logic [7:0] REG_RESET = 8'h00;

	// Writable bits of the device wake registers; bits 6 and 0 are reserved.
	localparam logic [7:0] DEV_WAKE_MASK = 8'hbe;
	// Master status and master enable live in bit 0 of their registers.
	localparam int MST_BIT = 0;

	// Device wake bit positions.
	localparam int DEV_BIT_IRQ = 7;
	localparam int DEV_BIT_RING = 5;
	localparam int DEV_BIT_MOUSE = 4;
	localparam int DEV_BIT_KEYS = 3;
	localparam int DEV_BIT_RI_A = 2;
	localparam int DEV_BIT_RI_B = 1;

	// Input management status and enable bit positions.
	localparam int IN_BIT_POINTER = 0;
	localparam int IN_BIT_KEYS = 1;
	localparam int IN_BIT_IR = 2;
	localparam int IN_BIT_BUTTON = 3;
	localparam int IN_BIT_KBC = 4;
	localparam int IN_BIT_TO_WAKE = 6;
	localparam int IN_BIT_PIN_DRIVE = 7;
	localparam int IN_BIT_SLEEP = 7;

	// Number of asynchronous wake-side inputs brought through the synchroniser.
	localparam int WAKE_IN_W = 15;

endpackage : wsa_pkg

// ===== src/wsa_edge_sync.sv
// Two-stage synchroniser with edge detection for a vector of inputs.
// Assumes the inputs are asynchronous levels and rst_n is already synchronised.
`timescale 1ns/1ps
`default_nettype none
module wsa_edge_sync
	import wsa_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter bit BOTH_EDGES = 1'b0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] evt
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
		logic [WIDTH-1:0] prev;
	} wsa_sync_s;

	wsa_sync_s q;
	wsa_sync_s d;

	// Next state: the first stage is read only by the second stage.
	always_comb begin
		d.meta = din;
		d.sync = q.meta;
		d.prev = q.sync;
	end

	// State registers.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// One pulse per rising transition, or per transition when BOTH_EDGES is set, taken from the settled stages only.
	assign evt = BOTH_EDGES ? (q.sync ^ q.prev) : (q.sync & ~q.prev);

	// A rising-edge pulse never lasts two cycles.
	a_edge_once: assert property (@(posedge clock) disable iff (!rst_n)
		(!BOTH_EDGES && |evt) |=> ((evt & $past(evt)) == '0))
		else $error("edge pulse lasted two cycles");

endmodule : wsa_edge_sync
`default_nettype wire

// ===== src/wsa_aggregator.sv
// Wake event and management interrupt aggregator with its register file.
// Assumes byte accesses on a synchronous port; rstn is battery power-on reset.
`timescale 1ns/1ps
`default_nettype none
module wsa_aggregator
	import wsa_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic device_irq_wake,
	input wire logic ring_input_wake_n,
	input wire logic pointer_wake,
	input wire logic keys_wake,
	input wire logic serial_a_ring_wake,
	input wire logic serial_b_ring_wake,
	input wire logic [7:0] wake_pin,
	input wire logic button_event,
	input wire logic infrared_rx_sel,
	input wire logic parallel_irq_flag,
	input wire logic serial_b_irq_flag,
	input wire logic serial_a_irq_flag,
	input wire logic floppy_irq_flag,
	input wire logic pin_group_b_irq_flag,
	input wire logic pin_group_a_irq_flag,
	input wire logic watchdog_irq_flag,
	input wire logic pointer_irq_flag,
	input wire logic keys_irq_flag,
	input wire logic kbc_port_pin_flag,
	input wire logic sleep_request_smi,
	input wire logic mgmt_serirq_select,
	output logic wake_req_n,
	output logic wake_req_oe,
	output logic group_mgmt_irq_n,
	output logic group_mgmt_irq_oe,
	output logic mgmt_serirq_req
);

	////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_q;
	logic rst_n_q;

	// Battery reset asserts at once and releases through two flip-flops.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	logic [WAKE_IN_W-1:0] wake_raw;
	logic [WAKE_IN_W-1:0] wake_evt;
	logic ir_evt;

	// The ring input is active low, so it is inverted before sampling.
	assign wake_raw = {button_event, wake_pin, device_irq_wake,
		~ring_input_wake_n, pointer_wake, keys_wake,
		serial_a_ring_wake, serial_b_ring_wake};

	wsa_edge_sync #(.WIDTH(WAKE_IN_W), .BOTH_EDGES(1'b0)) u_wake_sync (
		.clock(clock),
		.rst_n(rst_n_q),
		.din(wake_raw),
		.evt(wake_evt)
	);

	// The infrared input counts both edges after the receive multiplexer.
	wsa_edge_sync #(.WIDTH(1), .BOTH_EDGES(1'b1)) u_ir_sync (
		.clock(clock),
		.rst_n(rst_n_q),
		.din(infrared_rx_sel),
		.evt(ir_evt)
	);

	////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [7:0] dev_sts;
		logic [7:0] gpio_sts;
		logic [7:0] dev_en;
		logic [7:0] gpio_en;
		logic mst_sts;
		logic mst_en;
		logic [7:0] peripheral_smi_enable;
		logic [7:0] input_smi_enable;
		logic ir_flag;
		logic btn_flag;
		logic slp_flag;
		logic grp_prev;
		logic [7:0] rdata;
		logic wake_n;
		logic wake_oe;
		logic smi_n;
		logic smi_oe;
		logic serirq;
	} wsa_state_s;

	wsa_state_s q;
	wsa_state_s d;

	logic [7:0] dev_evt;
	logic [7:0] gpio_evt;
	logic btn_evt;
	logic [7:0] periph_sts;
	logic [7:0] input_sts;
	logic [7:0] smi1_src;
	logic grp;
	logic route_evt;
	logic mst_set;
	logic rd_input_sts;

	// Event pulses placed at their status bit positions.
	always_comb begin
		dev_evt = '0;
		dev_evt[DEV_BIT_IRQ] = wake_evt[5];
		dev_evt[DEV_BIT_RING] = wake_evt[4];
		dev_evt[DEV_BIT_MOUSE] = wake_evt[3];
		dev_evt[DEV_BIT_KEYS] = wake_evt[2];
		dev_evt[DEV_BIT_RI_A] = wake_evt[1];
		dev_evt[DEV_BIT_RI_B] = wake_evt[0];
		gpio_evt = wake_evt[13:6];
		btn_evt = wake_evt[14];
	end

	// Live and latched management status, and the group combination.
	always_comb begin
		periph_sts = {watchdog_irq_flag, pin_group_a_irq_flag,
			pin_group_b_irq_flag, floppy_irq_flag, serial_a_irq_flag,
			serial_b_irq_flag, parallel_irq_flag, 1'b0};
		input_sts = '0;
		input_sts[IN_BIT_POINTER] = pointer_irq_flag;
		input_sts[IN_BIT_KEYS] = keys_irq_flag;
		input_sts[IN_BIT_IR] = q.ir_flag;
		input_sts[IN_BIT_BUTTON] = q.btn_flag;
		input_sts[IN_BIT_KBC] = kbc_port_pin_flag;
		input_sts[IN_BIT_SLEEP] = q.slp_flag;
		// Ring wake status doubles as the ring management status.
		smi1_src = periph_sts;
		smi1_src[0] = q.dev_sts[DEV_BIT_RING];
		grp = (|(smi1_src & q.peripheral_smi_enable))
			| (|(input_sts[3:0] & q.input_smi_enable[3:0]))
			| (input_sts[IN_BIT_KBC] & q.input_smi_enable[IN_BIT_KBC]);
		route_evt = grp & ~q.grp_prev & q.input_smi_enable[IN_BIT_TO_WAKE];
		// Only enabled sources may arm the master status.
		mst_set = (|(dev_evt & q.dev_en)) | (|(gpio_evt & q.gpio_en))
			| route_evt;
		rd_input_sts = io_rd && (io_addr == OFF_INPUT_SMI_STS);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	// Register writes, sticky status with set winning over clear, outputs.
	always_comb begin
		d = q;
		d.grp_prev = grp;
		// Write-one-to-clear; a fresh event in the same cycle survives.
		d.dev_sts = (q.dev_sts & ~((io_wr && io_addr == OFF_DEV_WAKE_STS)
			? (io_wdata & DEV_WAKE_MASK) : 8'h00)) | dev_evt;
		d.gpio_sts = (q.gpio_sts & ~((io_wr && io_addr == OFF_GPIO_WAKE_STS)
			? io_wdata : 8'h00)) | gpio_evt;
		d.mst_sts = (q.mst_sts & ~(io_wr && io_addr == OFF_WAKE_MST_STS
			&& io_wdata[MST_BIT])) | mst_set;
		if (io_wr) begin
			unique case (io_addr)
				OFF_DEV_WAKE_EN: d.dev_en = io_wdata & DEV_WAKE_MASK;
				OFF_GPIO_WAKE_EN: d.gpio_en = io_wdata;
				OFF_WAKE_MST_EN: d.mst_en = io_wdata[MST_BIT];
				OFF_PERIPH_SMI_EN: d.peripheral_smi_enable = io_wdata;
				OFF_INPUT_SMI_EN: d.input_smi_enable = io_wdata & 8'hdf;
				default: d.mst_en = q.mst_en;
			endcase
		end
		// Latched input flags clear on a read; a same-cycle event wins.
		d.ir_flag = (q.ir_flag & ~rd_input_sts) | ir_evt;
		d.btn_flag = (q.btn_flag & ~rd_input_sts) | btn_evt;
		d.slp_flag = (q.slp_flag & ~rd_input_sts) | sleep_request_smi;
		// Read data returns the value before any clear-on-read.
		if (io_rd) begin
			unique case (io_addr)
				OFF_DEV_WAKE_STS: d.rdata = q.dev_sts;
				OFF_GPIO_WAKE_STS: d.rdata = q.gpio_sts;
				OFF_DEV_WAKE_EN: d.rdata = q.dev_en;
				OFF_GPIO_WAKE_EN: d.rdata = q.gpio_en;
				OFF_WAKE_MST_STS: d.rdata = {7'h00, q.mst_sts};
				OFF_WAKE_MST_EN: d.rdata = {7'h00, q.mst_en};
				OFF_PERIPH_SMI_STS: d.rdata = periph_sts;
				OFF_INPUT_SMI_STS: d.rdata = input_sts;
				OFF_PERIPH_SMI_EN: d.rdata = q.peripheral_smi_enable;
				OFF_INPUT_SMI_EN: d.rdata = q.input_smi_enable;
				default: d.rdata = 8'h00;
			endcase
		end
		// Open-drain wake request driven low while armed and enabled.
		d.wake_n = ~(d.mst_sts & d.mst_en);
		d.wake_oe = d.mst_sts & d.mst_en;
		// Group interrupt goes to the pin or the serial slot, else floats.
		d.smi_n = ~grp;
		d.smi_oe = q.input_smi_enable[IN_BIT_PIN_DRIVE] & ~mgmt_serirq_select;
		d.serirq = grp & q.input_smi_enable[IN_BIT_PIN_DRIVE] & mgmt_serirq_select;
	end

	// State registers; only the battery reset clears them.
	always_ff @(posedge clock or negedge rst_n_q) begin
		if (!rst_n_q) begin
			q <= '0;
			q.wake_n <= 1'b1;
			q.smi_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Ports come straight from the state flip-flops.
	assign io_rdata = q.rdata;
	assign wake_req_n = q.wake_n;
	assign wake_req_oe = q.wake_oe;
	assign group_mgmt_irq_n = q.smi_n;
	assign group_mgmt_irq_oe = q.smi_oe;
	assign mgmt_serirq_req = q.serirq;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	a_status_sticky: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		|gpio_evt |=> ((q.gpio_sts & $past(gpio_evt)) == $past(gpio_evt)))
		else $error("wake event did not set its status bit");

	a_zero_write_keeps: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		(io_wr && io_addr == OFF_GPIO_WAKE_STS)
		|=> ((q.gpio_sts & $past(q.gpio_sts & ~io_wdata))
			== $past(q.gpio_sts & ~io_wdata))
			&& ((q.gpio_sts & $past(io_wdata & ~gpio_evt)) == 8'h00))
		else $error("wake status write did not act as write-one-to-clear");

	a_wake_gated: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		!wake_req_n |-> (q.mst_en && q.mst_sts && wake_req_oe))
		else $error("wake request without master enable and status");

	a_disabled_quiet: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		$rose(q.mst_sts) |-> $past(mst_set))
		else $error("master status set without an enabled source");

	a_group_follows: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		$changed(grp) |=> (group_mgmt_irq_n == !$past(grp)))
		else $error("group interrupt pin does not follow its sources");

	a_pin_floats: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		!q.input_smi_enable[IN_BIT_PIN_DRIVE] |=> !group_mgmt_irq_oe && !mgmt_serirq_req)
		else $error("group interrupt driven while disabled");

	a_route_gate: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		($rose(q.mst_sts)
			&& !$past((|(dev_evt & q.dev_en)) || (|(gpio_evt & q.gpio_en))))
		|-> $past(q.input_smi_enable[IN_BIT_TO_WAKE]))
		else $error("group interrupt reached wake logic while not routed");

	a_live_read: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		(io_rd && io_addr == OFF_PERIPH_SMI_STS) |=> io_rdata == $past(periph_sts))
		else $error("peripheral status read is not live");

	a_ir_latch: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		ir_evt |=> q.ir_flag ##1 (q.ir_flag || $past(rd_input_sts)))
		else $error("infrared transition not latched");

	a_read_clears: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		(rd_input_sts && !btn_evt && !sleep_request_smi && !ir_evt)
		|=> !q.btn_flag && !q.slp_flag && !q.ir_flag)
		else $error("latched input flags survived a read");

	a_master_clear: assert property (@(posedge clock)
		disable iff (!rst_n_q)
		(io_wr && io_addr == OFF_WAKE_MST_STS && io_wdata[MST_BIT] && !mst_set)
		|=> !q.mst_sts && wake_req_n && !wake_req_oe)
		else $error("master status write did not stop the wake request");

endmodule : wsa_aggregator
`default_nettype wire

// ===== verif/wsa_host_model.sv
// Host model: issues byte register cycles on the block's access port.
// Assumes the block takes strobes on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module wsa_host_model (
	input wire logic clock,
	input wire logic [7:0] io_rdata,
	output logic [7:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata
);
	// The bus starts idle at time zero.
	initial begin
		io_addr = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// One-cycle write strobe; released data shows its inverse.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clock);
		io_wr = 1'b0;
		io_wdata = ~d;
	endtask : wr

	// One-cycle read strobe; data is taken once the answer has settled.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clock);
		io_rd = 1'b0;
		@(negedge clock);
		d = io_rdata;
	endtask : rd
endmodule : wsa_host_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the wake and management interrupt aggregator.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import wsa_pkg::*;
	logic clock, rstn;
	logic [7:0] io_addr, io_wdata, io_rdata, wake_pin;
	logic io_wr, io_rd, device_irq_wake, ring_input_wake_n, pointer_wake;
	logic keys_wake, serial_a_ring_wake, serial_b_ring_wake, button_event;
	logic infrared_rx_sel, parallel_irq_flag, serial_b_irq_flag;
	logic serial_a_irq_flag, floppy_irq_flag, pin_group_b_irq_flag;
	logic pin_group_a_irq_flag, watchdog_irq_flag, pointer_irq_flag;
	logic keys_irq_flag, kbc_port_pin_flag, sleep_request_smi;
	logic mgmt_serirq_select, wake_req_n, wake_req_oe, group_mgmt_irq_n;
	logic group_mgmt_irq_oe, mgmt_serirq_req;
	int fail_count, check_count, cycles;
	logic [7:0] offs [10] = '{OFF_DEV_WAKE_STS, OFF_GPIO_WAKE_STS,
		OFF_DEV_WAKE_EN, OFF_GPIO_WAKE_EN, OFF_WAKE_MST_STS, OFF_WAKE_MST_EN,
		OFF_PERIPH_SMI_STS, OFF_INPUT_SMI_STS, OFF_PERIPH_SMI_EN,
		OFF_INPUT_SMI_EN};

	wsa_host_model host (.clock, .io_rdata, .io_addr, .io_wr, .io_rd,
		.io_wdata);
	wsa_aggregator dut (.clock, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata,
		.io_rdata, .device_irq_wake, .ring_input_wake_n, .pointer_wake,
		.keys_wake, .serial_a_ring_wake, .serial_b_ring_wake, .wake_pin,
		.button_event, .infrared_rx_sel, .parallel_irq_flag,
		.serial_b_irq_flag, .serial_a_irq_flag, .floppy_irq_flag,
		.pin_group_b_irq_flag, .pin_group_a_irq_flag, .watchdog_irq_flag,
		.pointer_irq_flag, .keys_irq_flag, .kbc_port_pin_flag,
		.sleep_request_smi, .mgmt_serirq_select, .wake_req_n, .wake_req_oe,
		.group_mgmt_irq_n, .group_mgmt_irq_oe, .mgmt_serirq_req);

	// The clock toggles every 50 ns for a 100 ns period.
	always #50 clock = ~clock;

	// A hang is cut short after a fixed number of cycles.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			fail_count++;
			close_out();
		end
	end

	// Counts and reports one comparison.
	task automatic chk(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Reads a register and compares it.
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk($sformatf("register %h", a), d, exp);
	endtask : rc

	// Compares the pins; the group value only counts while it is driven.
	task automatic pins(input logic [7:0] exp);
		chk("output pins", {3'h0, mgmt_serirq_req, group_mgmt_irq_oe,
			group_mgmt_irq_n | ~group_mgmt_irq_oe, wake_req_oe, wake_req_n},
			exp);
	endtask : pins

	// Gives synchronisers and registered outputs time to settle.
	task automatic settle();
		repeat (6) @(negedge clock);
	endtask : settle

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	// Main sequence of tests.
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		{device_irq_wake, pointer_wake, keys_wake, serial_a_ring_wake} = '0;
		{serial_b_ring_wake, button_event, infrared_rx_sel} = '0;
		{parallel_irq_flag, serial_b_irq_flag, serial_a_irq_flag} = '0;
		{floppy_irq_flag, pin_group_b_irq_flag, pin_group_a_irq_flag} = '0;
		{watchdog_irq_flag, pointer_irq_flag, keys_irq_flag} = '0;
		{kbc_port_pin_flag, sleep_request_smi, mgmt_serirq_select} = '0;
		ring_input_wake_n = 1'b1;
		wake_pin = 8'h00;
		repeat (16) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		foreach (offs[i]) rc(offs[i], REG_RESET);
		rc(8'h20, 8'h00);
		pins(8'h05);
		$display("test reset done");
		wake_pin[3] = 1'b1;
		settle();
		rc(OFF_GPIO_WAKE_STS, 8'h08);
		pins(8'h05);
		rc(OFF_WAKE_MST_STS, 8'h00);
		host.wr(OFF_GPIO_WAKE_STS, 8'h00);
		rc(OFF_GPIO_WAKE_STS, 8'h08);
		host.wr(OFF_GPIO_WAKE_STS, 8'h08);
		rc(OFF_GPIO_WAKE_STS, 8'h00);
		host.wr(OFF_GPIO_WAKE_EN, 8'h01);
		host.wr(OFF_WAKE_MST_EN, 8'h01);
		wake_pin[0] = 1'b1;
		settle();
		pins(8'h06);
		rc(OFF_WAKE_MST_STS, 8'h01);
		host.wr(OFF_WAKE_MST_STS, 8'h01);
		settle();
		pins(8'h05);
		ring_input_wake_n = 1'b0;
		settle();
		rc(OFF_DEV_WAKE_STS, 8'h20);
		host.wr(OFF_DEV_WAKE_STS, 8'hff);
		rc(OFF_DEV_WAKE_STS, 8'h00);
		$display("test wake done");
		host.wr(OFF_PERIPH_SMI_EN, 8'h80);
		host.wr(OFF_INPUT_SMI_EN, 8'h40);
		watchdog_irq_flag = 1'b1;
		settle();
		rc(OFF_PERIPH_SMI_STS, 8'h80);
		pins(8'h06);
		host.wr(OFF_WAKE_MST_STS, 8'h01);
		host.wr(OFF_INPUT_SMI_EN, 8'hc0);
		settle();
		pins(8'h09);
		mgmt_serirq_select = 1'b1;
		settle();
		chk("serial slot", {7'h00, mgmt_serirq_req}, 8'h01);
		mgmt_serirq_select = 1'b0;
		host.wr(OFF_PERIPH_SMI_EN, 8'h00);
		settle();
		pins(8'h0d);
		watchdog_irq_flag = 1'b0;
		$display("test group done");
		{pointer_irq_flag, keys_irq_flag, kbc_port_pin_flag} = 3'b111;
		{infrared_rx_sel, button_event, sleep_request_smi} = 3'b111;
		@(negedge clock);
		sleep_request_smi = 1'b0;
		settle();
		rc(OFF_INPUT_SMI_STS, 8'h9f);
		rc(OFF_INPUT_SMI_STS, 8'h13);
		host.wr(OFF_INPUT_SMI_EN, 8'h90);
		settle();
		pins(8'h09);
		host.wr(OFF_INPUT_SMI_EN, 8'h80);
		settle();
		pins(8'h0d);
		host.wr(OFF_INPUT_SMI_EN, 8'h81);
		settle();
		pins(8'h09);
		{pointer_irq_flag, keys_irq_flag, kbc_port_pin_flag} = 3'b000;
		ring_input_wake_n = 1'b1;
		settle();
		ring_input_wake_n = 1'b0;
		host.wr(OFF_INPUT_SMI_EN, 8'h80);
		host.wr(OFF_PERIPH_SMI_EN, 8'h01);
		settle();
		pins(8'h09);
		// A falling infrared edge must latch the flag as a rising one does.
		infrared_rx_sel = 1'b0;
		settle();
		rc(OFF_INPUT_SMI_STS, 8'h04);
		$display("test input done");
		// The ring source, once enabled, raises the wake request.
		host.wr(OFF_DEV_WAKE_EN, 8'h20);
		ring_input_wake_n = 1'b1;
		settle();
		ring_input_wake_n = 1'b0;
		settle();
		pins(8'h0a);
		rc(OFF_DEV_WAKE_EN, 8'h20);
		$display("test device wake done");
		// A battery reset in mid-run returns every register to zero.
		{wake_pin, button_event, ring_input_wake_n} = {8'h00, 1'b0, 1'b1};
		settle();
		rstn = 1'b0;
		repeat (3) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
		foreach (offs[i]) rc(offs[i], REG_RESET);
		pins(8'h05);
		$display("test second reset done");
		close_out();
	end
endmodule : tb
`default_nettype wire
